// ### shared/lmc_pkg.sv
// package for the lcd misc control register bank
// assumes the plain register port with byte-wide data, 17-bit addresses
package lmc_pkg;

  // register port geometry
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;

  // register offsets, byte addresses on the plain port
  localparam logic [16:0] OFS_PAL_ADDR = 17'h1FFF5;
  localparam logic [16:0] OFS_PAL_DATA = 17'h1FFF7;
  localparam logic [16:0] OFS_PIN_DIR = 17'h1FFF8;
  localparam logic [16:0] OFS_PIN_STAT = 17'h1FFF9;
  localparam logic [16:0] OFS_SCRATCH = 17'h1FFFA;
  localparam logic [16:0] OFS_ROT = 17'h1FFFB;

  // general pins
  localparam int PIN_COUNT = 5;
  localparam logic [7:0] PIN_MASK = 8'h1F;

  // palette geometry and data lane
  localparam int PAL_DEPTH = 256;
  localparam int PAL_IDX_W = 8;
  localparam int COMP_W = 4;
  localparam int PAL_DATA_LSB = 4;

  // rotation mode field positions
  localparam int ROT_EN_BIT = 7;
  localparam int ROT_SEL_BIT = 6;
  localparam int ROT_RSV_BIT = 2;
  localparam int ROT_PCLK_LSB = 0;
  localparam logic [7:0] ROT_WMASK = 8'hC3;

  // reset values
  localparam logic [7:0] RST_PIN_DIR = 8'h00;
  localparam logic [7:0] RST_PIN_STAT = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] RST_ROT = 8'h00;
  localparam logic [3:0] RST_COMP = 4'h0;

  // drive of the general pins
  typedef struct packed {
    logic [PIN_COUNT-1:0] out;
    logic [PIN_COUNT-1:0] oe;
  } lmc_pin_drive_type;

  // one palette entry
  typedef struct packed {
    logic [COMP_W-1:0] red;
    logic [COMP_W-1:0] green;
    logic [COMP_W-1:0] blue;
  } lmc_rgb_type;

  // decoded rotation controls
  typedef struct packed {
    logic enable;
    logic alternate;
    logic [1:0] pclk_sel;
  } lmc_rot_type;

  // component pointer position
  typedef enum logic [1:0] {COMP_RED, COMP_GREEN, COMP_BLUE} lmc_comp_type;

endpackage

// ### logic/lmc_pins.sv
// direction and level muxing for the general pins
// assumes pin inputs synchronous to clk; purely combinational
`timescale 1ns/1ns
module lmc_pins (
  // software state
  input wire logic [lmc_pkg::PIN_COUNT-1:0] dir,
  input wire logic [lmc_pkg::PIN_COUNT-1:0] stat,
  // dedicated panel function takeover
  input wire logic [lmc_pkg::PIN_COUNT-1:0] func_en,
  input wire logic [lmc_pkg::PIN_COUNT-1:0] func_out,
  input wire logic [lmc_pkg::PIN_COUNT-1:0] func_oe,
  // pins
  input wire logic [lmc_pkg::PIN_COUNT-1:0] pin_in,
  output lmc_pkg::lmc_pin_drive_type pin_drive,
  // level seen by a status read
  output logic [lmc_pkg::PIN_COUNT-1:0] level
);
  import lmc_pkg::*;

  // one slice per pin
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    // a taken-over pin follows its panel function, not software
    assign pin_drive.oe[i] = func_en[i] ? func_oe[i] : dir[i];
    assign pin_drive.out[i] = func_en[i] ? func_out[i] : stat[i];
    // software outputs read back the held value; inputs and taken-over pins read the live level
    assign level[i] = (dir[i] & ~func_en[i]) ? stat[i] : pin_in[i];
  end

endmodule

// ### logic/lmc_palette.sv
// palette table with staged colour commit and auto pointer
// assumes at most one palette access per cycle
`timescale 1ns/1ns
module lmc_palette #(
  parameter int DEPTH = lmc_pkg::PAL_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // software access
  input wire logic index_wr,
  input wire logic [lmc_pkg::PAL_IDX_W-1:0] index_wdata,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [lmc_pkg::COMP_W-1:0] data_wdata,
  output logic [lmc_pkg::COMP_W-1:0] data_rdata,
  output logic [lmc_pkg::PAL_IDX_W-1:0] ptr_index,
  // display lookup
  input wire logic [lmc_pkg::PAL_IDX_W-1:0] look_index,
  output lmc_pkg::lmc_rgb_type look_rgb
);
  import lmc_pkg::*;

  lmc_rgb_type table_q [DEPTH];
  lmc_rgb_type next_table [DEPTH];
  lmc_comp_type ptr_comp, next_ptr_comp;
  logic [PAL_IDX_W-1:0] next_ptr_index;
  logic [COMP_W-1:0] stage_red, next_stage_red;
  logic [COMP_W-1:0] stage_green, next_stage_green;
  lmc_rgb_type next_look_rgb;
  lmc_rgb_type cur;

  // component currently addressed, for reads
  assign cur = table_q[ptr_index];
  always_comb begin
    case (ptr_comp)
      COMP_RED: data_rdata = cur.red;
      COMP_GREEN: data_rdata = cur.green;
      default: data_rdata = cur.blue;
    endcase
  end

  // pointer walk, staging and commit
  always_comb begin
    next_table = table_q;
    next_ptr_index = ptr_index;
    next_ptr_comp = ptr_comp;
    next_stage_red = stage_red;
    next_stage_green = stage_green;
    next_look_rgb = table_q[look_index];
    if (index_wr) begin
      next_ptr_index = index_wdata;
      next_ptr_comp = COMP_RED;
    end else if (data_wr || data_rd) begin
      case (ptr_comp)
        COMP_RED: begin
          if (data_wr) next_stage_red = data_wdata;
          next_ptr_comp = COMP_GREEN;
        end
        COMP_GREEN: begin
          if (data_wr) next_stage_green = data_wdata;
          next_ptr_comp = COMP_BLUE;
        end
        default: begin
          // entry changes only here, so the display never sees half a colour
          if (data_wr) begin
            next_table[ptr_index] = {stage_red, stage_green, data_wdata};
          end
          next_ptr_comp = COMP_RED;
          next_ptr_index = ptr_index + 1'b1;
        end
      endcase
    end
  end

  // registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) table_q[i] <= '0;
      ptr_index <= '0;
      ptr_comp <= COMP_RED;
      stage_red <= RST_COMP;
      stage_green <= RST_COMP;
      look_rgb <= '0;
    end else begin
      table_q <= next_table;
      ptr_index <= next_ptr_index;
      ptr_comp <= next_ptr_comp;
      stage_red <= next_stage_red;
      stage_green <= next_stage_green;
      look_rgb <= next_look_rgb;
    end
  end

endmodule

// ### logic/lmc_regs.sv
// misc control register bank of the lcd controller
// assumes a plain register port: one-cycle strobes, read data a cycle later
//
// Functional notes
// - palette entry commits only after blue write
// - address write resets pointer; accesses advance it
// - direction bit zero makes pin an input
// - direction bit one drives pin from status
// - input pin status read returns live level
// - output pin shows stored status value
// - scratch byte stores and returns, no effect
// - rotation bit 7 selects portrait display
// - bit 6 picks rotated method when enabled
`timescale 1ns/1ns
module lmc_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [lmc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lmc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [lmc_pkg::DATA_W-1:0] reg_rdata,
  // general pins
  input wire logic [lmc_pkg::PIN_COUNT-1:0] pin_in,
  output lmc_pkg::lmc_pin_drive_type pin_drive,
  // dedicated panel function on the general pins
  input wire logic [lmc_pkg::PIN_COUNT-1:0] func_en,
  input wire logic [lmc_pkg::PIN_COUNT-1:0] func_out,
  input wire logic [lmc_pkg::PIN_COUNT-1:0] func_oe,
  // rotation controls to the display path
  output lmc_pkg::lmc_rot_type rot_ctrl,
  output logic portrait_default,
  output logic portrait_alternate,
  // palette lookup from the display path
  input wire logic [lmc_pkg::PAL_IDX_W-1:0] look_index,
  output lmc_pkg::lmc_rgb_type look_rgb
);
  import lmc_pkg::*;

  // stored registers
  logic [DATA_W-1:0] pin_dir, next_pin_dir;
  logic [DATA_W-1:0] pin_stat, next_pin_stat;
  logic [DATA_W-1:0] scratch, next_scratch;
  logic [DATA_W-1:0] rot_mode, next_rot_mode;
  logic [DATA_W-1:0] next_reg_rdata;

  // decode
  logic hit_pal_addr;
  logic hit_pal_data;
  logic hit_pin_dir;
  logic hit_pin_stat;
  logic hit_scratch;
  logic hit_rot;

  // palette and pin helpers
  logic [COMP_W-1:0] pal_rdata;
  logic [PAL_IDX_W-1:0] pal_ptr;
  logic [PIN_COUNT-1:0] pin_level;

  // address decode, exact match on the full address
  assign hit_pal_addr = (reg_addr == OFS_PAL_ADDR);
  assign hit_pal_data = (reg_addr == OFS_PAL_DATA);
  assign hit_pin_dir = (reg_addr == OFS_PIN_DIR);
  assign hit_pin_stat = (reg_addr == OFS_PIN_STAT);
  assign hit_scratch = (reg_addr == OFS_SCRATCH);
  assign hit_rot = (reg_addr == OFS_ROT);

  // register write path
  always_comb begin
    next_pin_dir = pin_dir;
    next_pin_stat = pin_stat;
    next_scratch = scratch;
    next_rot_mode = rot_mode;
    if (reg_wr) begin
      if (hit_pin_dir) begin
        next_pin_dir = reg_wdata & PIN_MASK;
      end
      // held even for input pins, so a later switch to output
      // drives a known value instead of a stale one
      if (hit_pin_stat) begin
        next_pin_stat = reg_wdata & PIN_MASK;
      end
      if (hit_scratch) begin
        next_scratch = reg_wdata;
      end
      // reserved bit 2 is dropped, a careless write cannot set it
      if (hit_rot) begin
        next_rot_mode = reg_wdata & ROT_WMASK;
      end
    end
  end

  // register state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_dir <= RST_PIN_DIR;
      pin_stat <= RST_PIN_STAT;
      scratch <= RST_SCRATCH;
      rot_mode <= RST_ROT;
    end else begin
      pin_dir <= next_pin_dir;
      pin_stat <= next_pin_stat;
      scratch <= next_scratch;
      rot_mode <= next_rot_mode;
    end
  end

  // read mux; unmapped addresses and idle cycles give zero
  always_comb begin
    next_reg_rdata = 8'h00;
    if (reg_rd) begin
      if (hit_pal_addr) begin
        next_reg_rdata = pal_ptr;
      end else if (hit_pal_data) begin
        next_reg_rdata = {pal_rdata, 4'h0};
      end else if (hit_pin_dir) begin
        next_reg_rdata = pin_dir;
      end else if (hit_pin_stat) begin
        next_reg_rdata = {3'h0, pin_level};
      end else if (hit_scratch) begin
        next_reg_rdata = scratch;
      end else if (hit_rot) begin
        next_reg_rdata = rot_mode;
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // rotation controls, straight from the stored bits
  assign rot_ctrl.enable = rot_mode[ROT_EN_BIT];
  assign rot_ctrl.alternate = rot_mode[ROT_SEL_BIT];
  assign rot_ctrl.pclk_sel = rot_mode[ROT_PCLK_LSB+:2];
  // method select means nothing in landscape, so gate it here once
  assign portrait_default = rot_mode[ROT_EN_BIT] & ~rot_mode[ROT_SEL_BIT];
  assign portrait_alternate = rot_mode[ROT_EN_BIT] & rot_mode[ROT_SEL_BIT];

  // general pin muxing
  lmc_pins u_pins (
    .dir(pin_dir[PIN_COUNT-1:0]),
    .stat(pin_stat[PIN_COUNT-1:0]),
    .func_en(func_en),
    .func_out(func_out),
    .func_oe(func_oe),
    .pin_in(pin_in),
    .pin_drive(pin_drive),
    .level(pin_level)
  );

  // palette; reads as well as writes walk the pointer
  lmc_palette #(
    .DEPTH(PAL_DEPTH)
  ) u_palette (
    .clk(clk),
    .rstn(rstn),
    .index_wr(reg_wr & hit_pal_addr),
    .index_wdata(reg_wdata),
    .data_wr(reg_wr & hit_pal_data),
    .data_rd(reg_rd & hit_pal_data),
    .data_wdata(reg_wdata[PAL_DATA_LSB+:COMP_W]),
    .data_rdata(pal_rdata),
    .ptr_index(pal_ptr),
    .look_index(look_index),
    .look_rgb(look_rgb)
  );

endmodule

// ### verif/lmc_regs_props.sv
// checker for the misc control register bank
// assumes a bind to lmc_regs from the bench top
`timescale 1ns/1ns
module lmc_regs_props (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [16:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins and display controls
  input wire logic [4:0] pin_in,
  input wire lmc_pkg::lmc_pin_drive_type pin_drive,
  input wire logic [4:0] func_en,
  input wire logic [4:0] func_out,
  input wire logic [4:0] func_oe,
  input wire lmc_pkg::lmc_rot_type rot_ctrl,
  input wire logic portrait_default
);
  import lmc_pkg::*;
  logic [7:0] wd_q;
  logic [4:0] pin_q, live_q;
  // strobe decodes; own marks pins driven from status
  wire wdir = reg_wr && reg_addr == OFS_PIN_DIR;
  wire wst = reg_wr && reg_addr == OFS_PIN_STAT;
  wire wrot = reg_wr && reg_addr == OFS_ROT;
  wire rpin = reg_rd && (reg_addr == OFS_PIN_STAT || reg_addr == OFS_PIN_DIR);
  wire rst = reg_rd && reg_addr == OFS_PIN_STAT;
  wire [4:0] own = ~func_en & pin_drive.oe;
  // copies of the strobe cycle, seen by the consequents
  always_ff @(posedge clk) begin
    wd_q <= reg_wdata;
    pin_q <= pin_in;
    live_q <= ~pin_drive.oe | func_en;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_dir;
    wdir |=> (pin_drive.oe & ~func_en) == (wd_q[4:0] & ~func_en);
  endproperty
  a_dir: assert property (p_dir) else $error("dir to enable");
  // masked difference is parenthesised: == binds tighter than &
  property p_func;
    ##0 ((((pin_drive.oe ^ func_oe) | (pin_drive.out ^ func_out))
      & func_en) == 5'h00);
  endproperty
  a_func: assert property (p_func) else $error("takeover");
  property p_out;
    wst |=> ((pin_drive.out ^ wd_q[4:0]) & own) == 5'h00;
  endproperty
  a_out: assert property (p_out) else $error("pin out");
  property p_in;
    rst |=> ((reg_rdata[4:0] ^ pin_q) & live_q) == 5'h00;
  endproperty
  a_in: assert property (p_in) else $error("pin level read");
  property p_unused;
    rpin |=> reg_rdata[7:5] == 3'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bits");
  property p_scratch;
    reg_wr && reg_addr == OFS_SCRATCH |=> $stable(rot_ctrl) && $stable(own);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch side");
  property p_rot;
    wrot |=> rot_ctrl.enable == wd_q[7] && rot_ctrl.alternate == wd_q[6]
      && portrait_default == (wd_q[7] & ~wd_q[6]);
  endproperty
  a_rot: assert property (p_rot) else $error("rotation");
  property p_hold;
    !wrot |=> $stable(rot_ctrl);
  endproperty
  a_hold: assert property (p_hold) else $error("rotation moved");
endmodule

// ### verif/lmc_pin_partner.sv
// far-side circuitry on the general pins
// assumes the pin drive struct of the bank
`timescale 1ns/1ns
module lmc_pin_partner (
  // from the bank
  input wire lmc_pkg::lmc_pin_drive_type pin_drive,
  // external source
  input wire logic [4:0] ext_val,
  input wire logic [4:0] ext_oe,
  // level back to the bank
  output logic [4:0] pin_in
);
  import lmc_pkg::*;
  // undriven pins sit high, tied to the io supply
  always_comb begin
    pin_in = (pin_drive.out & pin_drive.oe) | (ext_val & ext_oe)
      | ~(pin_drive.oe | ext_oe);
  end
endmodule

// ### verif/tb_lcd_misc_control_regs.sv
// self-checking bench for the misc control register bank
// assumes design, partner and checker compiled before it
`timescale 1ns/1ns
module tb_lcd_misc_control_regs;
  import lmc_pkg::*;
  typedef struct packed {
    logic [16:0] a;
    logic [7:0] w;
    logic [7:0] r;
  } lmc_row_type;
  logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [16:0] reg_addr = 17'h00000;
  logic [7:0] reg_wdata = 8'h00, look_index = 8'h00, reg_rdata, d;
  logic [4:0] fen = 5'h00, fout = 5'h00, foe = 5'h00;
  logic [4:0] ev = 5'h00, eo = 5'h1F, pin_in;
  lmc_pin_drive_type drv;
  lmc_rot_type rot;
  lmc_rgb_type rgb;
  logic pd, pa;
  int errors = 0, n_tests = 0, cyc = 0;
  // unmapped address sits in the table too
  lmc_row_type rows [8] = '{'{OFS_SCRATCH, 8'hA5, 8'hA5},
    '{OFS_SCRATCH, 8'h5A, 8'h5A}, '{OFS_PIN_DIR, 8'hFF, 8'h1F},
    '{OFS_PIN_DIR, 8'h00, 8'h00}, '{OFS_ROT, 8'hC3, 8'hC3},
    '{OFS_ROT, 8'h78, 8'h40}, '{17'h1FFF0, 8'hFF, 8'h00},
    '{OFS_PAL_ADDR, 8'h07, 8'h07}};
  lmc_regs u_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_drive(drv),
    .func_en(fen), .func_out(fout), .func_oe(foe), .rot_ctrl(rot),
    .portrait_default(pd), .portrait_alternate(pa),
    .look_index(look_index), .look_rgb(rgb));
  lmc_pin_partner u_far (.pin_drive(drv), .ext_val(ev), .ext_oe(eo),
    .pin_in(pin_in));
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [16:0] a, input logic [7:0] w);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [16:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard, tests need well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      stop_test;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(OFS_PIN_DIR + 17'(i));
      chk(d, 8'h00);
    end
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk(d, rows[i].r);
      if (rows[i].a == OFS_ROT)
        chk({pa, pd}, {rows[i].w[7] & rows[i].w[6],
          rows[i].w[7] & ~rows[i].w[6]});
    end
    $display("table test done");
    // pin 4 stays input and is driven low from outside
    eo <= 5'h10;
    wr(OFS_PIN_DIR, 8'h0F);
    wr(OFS_PIN_STAT, 8'h15);
    // wait past the edge that loads the status register
    #1 chk(drv.oe, 5'h0F);
    chk(drv.out & drv.oe, 5'h05);
    rd(OFS_PIN_STAT);
    chk(d, 8'h05);
    ev <= 5'h10;
    rd(OFS_PIN_STAT);
    chk(d, 8'h15);
    eo <= 5'h00;
    wr(OFS_PIN_DIR, 8'h1F);
    #1 chk(drv.out & drv.oe, 5'h15);
    fen <= 5'h01;
    foe <= 5'h01;
    #1 chk(drv.out[0], 1'b0);
    rd(OFS_PIN_STAT);
    chk(d[0], 1'b0);
    fen <= 5'h00;
    $display("pin test done");
    // red and green staged, nothing shows before blue
    look_index <= 8'h03;
    wr(OFS_PAL_ADDR, 8'h03);
    wr(OFS_PAL_DATA, 8'hA0);
    wr(OFS_PAL_DATA, 8'hB0);
    repeat (2) @(posedge clk);
    #1 chk(rgb, 12'h000);
    wr(OFS_PAL_DATA, 8'hC0);
    repeat (2) @(posedge clk);
    #1 chk(rgb, 12'hABC);
    rd(OFS_PAL_ADDR);
    chk(d, 8'h04);
    wr(OFS_PAL_ADDR, 8'h03);
    for (int i = 0; i < 3; i++) begin
      rd(OFS_PAL_DATA);
      chk(d, 8'hA0 + 8'(i) * 8'h10);
    end
    rd(OFS_PAL_ADDR);
    chk(d, 8'h04);
    $display("palette test done");
    stop_test;
  end
endmodule
bind lmc_regs lmc_regs_props u_props (.clk(clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
  .pin_drive(pin_drive), .func_en(func_en), .func_out(func_out),
  .func_oe(func_oe), .rot_ctrl(rot_ctrl),
  .portrait_default(portrait_default));
